// ---- core/sfx_consts.vh ----
`ifndef SFX_CONSTS_VH
`define SFX_CONSTS_VH

// Instruction codes
`define SFX_OP_WREN 8'h06
`define SFX_OP_WRDI 8'h04
`define SFX_OP_RDSR 8'h05
`define SFX_OP_WRSR 8'h01
`define SFX_OP_VOLEN 8'h50
`define SFX_OP_READ 8'h03
`define SFX_OP_FAST 8'h0b
`define SFX_OP_RDID 8'hab
`define SFX_OP_MFID 8'h90
`define SFX_OP_STDID 8'h9f

// Status register layout
`define SFX_SR_BUSY 0
`define SFX_SR_WEL 1
`define SFX_SR_LOCK 7
`define SFX_SR_WMASK 8'hbc
`define SFX_SR_RESET 8'h00

// Frame lengths in serial clock bits
`define SFX_OP_BITS 5'd8
`define SFX_ADDR_BITS 5'd24
`define SFX_DUMMY_BITS 5'd8

// Identification bytes, values arbitrary
`define SFX_MFR_ID 8'h3c
`define SFX_DEV_ID 8'h21
`define SFX_MEM_TYPE 8'h52
`define SFX_CAPACITY 8'h17

// Timing
`define SFX_CLK_PERIOD_NS 10
`define SFX_STATUS_WRITE_TIME_NS 15000000

// Byte fill when the read buffer has run dry
`define SFX_FILL_BYTE 8'hff

`endif

// ---- core/sfx_flash_front.v ----
// Function
// - Write-enable opcode then deselect sets the write latch flag.
// - Write-disable opcode then deselect clears the write latch flag.
// - Latch flag cleared at reset and when a status write cycle completes.
// - Status read shifts eight status bits out MSB first on falling edges.
// - Status byte repeats with fresh value until chip select rises.
// - Status read accepted at any time, even while busy.
// - Status write is opcode plus one byte; non-volatile write needs latch set, volatile does not.
// - Status write changes only bits 7, 5, 4, 3 and 2.
// - Status write discarded unless deselect lands on a byte boundary.
// - Non-volatile status write runs a timed busy cycle, then clears latch.
// - Volatile status write updates at deselect with busy kept low.
// - With lock bit set, status writes refused while guard pin is low.
// - Guard bits mark read-only areas for program and erase logic.
// - Normal read: opcode, 24-bit address, then data MSB first.
// - Read address increments per byte, streaming until deselect.
// - Normal read issued while busy is ignored.
// - Fast read adds eight ignored dummy clocks before data.
// - Device id opcode repeats device id byte until deselect.
// - Id opcodes return maker and device, or maker, type, capacity.
// - All bytes travel MSB first; read bytes leave on serial output.
// - Chip select falling starts an instruction; first byte is opcode.
// - While busy every instruction except status read is ignored.
`timescale 1ns/1ps
`include "sfx_consts.vh"

module sfx_flash_front #(
  parameter ADDR_W = 24,
  parameter TW_CYCLES = `SFX_STATUS_WRITE_TIME_NS / `SFX_CLK_PERIOD_NS
) (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire chip_sel_n,
  input wire ser_clk,
  input wire serial_in,
  input wire write_guard_n,
  output reg serial_out,
  output reg serial_out_oe,
  output wire mem_req_valid,
  input wire mem_req_ready,
  output reg [ADDR_W-1:0] mem_req_addr,
  input wire mem_rd_valid,
  output wire mem_rd_ready,
  input wire [7:0] mem_rd_data,
  output wire [7:0] status_out,
  output wire [2:0] block_guard,
  output wire busy
);

  localparam S_IDLE = 3'd0;
  localparam S_CMD = 3'd1;
  localparam S_ADDR = 3'd2;
  localparam S_DUMMY = 3'd3;
  localparam S_WDATA = 3'd4;
  localparam S_OUT = 3'd5;
  localparam S_HOLD = 3'd6;

  localparam SRC_STAT = 2'd0;
  localparam SRC_DATA = 2'd1;
  localparam SRC_ID = 2'd2;
  localparam SRC_JID = 2'd3;

  localparam [31:0] TW_LAST = TW_CYCLES - 1;

  // Pin synchronisers, third stage only for edge detection
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg ck_s1_q, ck_s2_q, ck_s3_q;
  reg di_s1_q, di_s2_q;
  reg wp_s1_q, wp_s2_q;

  wire cs_act = ~cs_s2_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire ck_rise = ck_s2_q & ~ck_s3_q & cs_act & ~cs_s3_q;
  wire ck_fall = ~ck_s2_q & ck_s3_q & cs_act & ~cs_s3_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      di_s1_q <= 1'b0;
      di_s2_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else if (clk_en) begin
      cs_s1_q <= chip_sel_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= ser_clk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      di_s1_q <= serial_in;
      di_s2_q <= di_s1_q;
      wp_s1_q <= write_guard_n;
      wp_s2_q <= wp_s1_q;
    end
  end

  // Frame state
  reg [2:0] st_q;
  reg [7:0] op_q;
  reg [7:0] sh_in_q;
  reg [4:0] bcnt_q;
  reg [ADDR_W-1:0] addr_q;
  reg [1:0] src_q;
  reg [1:0] idx_q;
  reg void_q;
  reg extra_q;
  reg [7:0] wbyte_q;
  reg wgot_q;
  reg [2:0] wpos_q;
  reg [7:0] osh_q;
  reg [2:0] ocnt_q;
  reg fetch_q;

  // Status state
  reg [7:0] nv_q;
  reg wel_q;
  reg busy_q;
  reg vol_q;
  reg [7:0] pend_q;
  reg [31:0] tw_cnt_q;

  // Two-entry read buffer
  reg [7:0] fifo_q [0:1];
  reg wr_ptr_q, rd_ptr_q;
  reg [1:0] fcnt_q;
  reg [1:0] outst_q;

  wire [7:0] status_w = {nv_q[7], 1'b0, nv_q[5:2], wel_q, busy_q};
  wire [7:0] op_w = {sh_in_q[6:0], di_s2_q};
  wire [ADDR_W-1:0] addr_w = {addr_q[ADDR_W-2:0], di_s2_q};
  wire guard_ok = ~nv_q[`SFX_SR_LOCK] | wp_s2_q;

  assign status_out = status_w;
  assign block_guard = nv_q[4:2];
  assign busy = busy_q;

  // Credit keeps buffer plus in-flight fetches within two entries
  // A raised request stands until taken; a new frame waits until old replies drain
  reg req_pend_q;
  reg drain_q;
  wire fetch_ok = fetch_q & ~drain_q;
  wire [2:0] credit = {1'b0, fcnt_q} + {1'b0, outst_q};
  assign mem_req_valid = req_pend_q | (fetch_ok & (credit < 3'd2));
  assign mem_rd_ready = fetch_ok ? (fcnt_q != 2'd2) : 1'b1;
  wire req_fire = mem_req_valid & mem_req_ready;
  wire rsp_fire = mem_rd_valid & mem_rd_ready;
  wire push = rsp_fire & fetch_ok;

  // Next output byte
  reg [7:0] nb;
  always @* begin
    case (src_q)
      SRC_STAT: nb = status_w;
      SRC_DATA: nb = (fcnt_q != 2'd0) ? fifo_q[rd_ptr_q] : `SFX_FILL_BYTE;
      SRC_ID: nb = (idx_q == 2'd1) ? `SFX_MFR_ID : `SFX_DEV_ID;
      SRC_JID: begin
        case (idx_q)
          2'd0: nb = `SFX_MFR_ID;
          2'd1: nb = `SFX_MEM_TYPE;
          default: nb = `SFX_CAPACITY;
        endcase
      end
      default: nb = `SFX_FILL_BYTE;
    endcase
  end

  wire load_byte = ck_fall & (st_q == S_OUT) & (ocnt_q == 3'd0);
  wire pop = load_byte & (src_q == SRC_DATA) & (fcnt_q != 2'd0);

  // Opcode dispatch once the eighth bit is in
  reg [2:0] disp_st;
  reg [1:0] disp_src;
  reg disp_void;
  always @* begin
    disp_src = SRC_STAT;
    disp_void = 1'b0;
    // Only status read passes while busy
    // busy filter
    if (busy_q && op_w != `SFX_OP_RDSR) begin
      disp_st = S_HOLD;
      disp_void = 1'b1;
    end else begin
      case (op_w)
        `SFX_OP_RDSR: disp_st = S_OUT;
        `SFX_OP_WREN: disp_st = S_HOLD;
        `SFX_OP_WRDI: disp_st = S_HOLD;
        `SFX_OP_VOLEN: disp_st = S_HOLD;
        `SFX_OP_WRSR: disp_st = S_WDATA;
        `SFX_OP_READ: disp_st = S_ADDR;
        `SFX_OP_FAST: disp_st = S_ADDR;
        `SFX_OP_RDID: disp_st = S_ADDR;
        `SFX_OP_MFID: disp_st = S_ADDR;
        `SFX_OP_STDID: begin
          disp_st = S_OUT;
          disp_src = SRC_JID;
        end
        default: begin
          disp_st = S_HOLD;
          disp_void = 1'b1;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      st_q <= S_IDLE;
      op_q <= 8'h00;
      sh_in_q <= 8'h00;
      bcnt_q <= 5'd0;
      addr_q <= {ADDR_W{1'b0}};
      src_q <= SRC_STAT;
      idx_q <= 2'd0;
      void_q <= 1'b0;
      extra_q <= 1'b0;
      wbyte_q <= 8'h00;
      wgot_q <= 1'b0;
      wpos_q <= 3'd0;
      osh_q <= 8'h00;
      ocnt_q <= 3'd0;
      fetch_q <= 1'b0;
      mem_req_addr <= {ADDR_W{1'b0}};
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      nv_q <= `SFX_SR_RESET;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      vol_q <= 1'b0;
      pend_q <= 8'h00;
      tw_cnt_q <= 32'd0;
    end else if (clk_en) begin
      if (busy_q) begin
        if (tw_cnt_q >= TW_LAST) begin
          nv_q <= (nv_q & ~`SFX_SR_WMASK) | (pend_q & `SFX_SR_WMASK);
          busy_q <= 1'b0;
          wel_q <= 1'b0;
        end else begin
          tw_cnt_q <= tw_cnt_q + 32'd1;
        end
      end
      if (req_fire) begin
        mem_req_addr <= mem_req_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
      if (cs_fall) begin
        st_q <= S_CMD;
        bcnt_q <= 5'd0;
        void_q <= 1'b0;
        extra_q <= 1'b0;
        wgot_q <= 1'b0;
        wpos_q <= 3'd0;
        ocnt_q <= 3'd0;
        idx_q <= 2'd0;
      end else if (cs_rise) begin
        st_q <= S_IDLE;
        fetch_q <= 1'b0;
        serial_out_oe <= 1'b0;
        if (!(st_q == S_HOLD && !void_q && op_q == `SFX_OP_VOLEN)) begin
          vol_q <= 1'b0;
        end
        if (st_q == S_HOLD && !void_q && !extra_q) begin
          case (op_q)
            `SFX_OP_WREN: wel_q <= 1'b1;
            `SFX_OP_WRDI: wel_q <= 1'b0;
            `SFX_OP_VOLEN: vol_q <= 1'b1;
            default: vol_q <= 1'b0;
          endcase
        end
        if (st_q == S_WDATA && wgot_q && wpos_q == 3'd0 && guard_ok) begin
          if (vol_q) begin
            nv_q <= (nv_q & ~`SFX_SR_WMASK) | (wbyte_q & `SFX_SR_WMASK);
          end else if (wel_q) begin
            pend_q <= wbyte_q;
            busy_q <= 1'b1;
            tw_cnt_q <= 32'd0;
          end
        end
      end else if (ck_rise) begin
        case (st_q)
          S_CMD: begin
            sh_in_q <= op_w;
            bcnt_q <= bcnt_q + 5'd1;
            if (bcnt_q == `SFX_OP_BITS - 5'd1) begin
              op_q <= op_w;
              st_q <= disp_st;
              src_q <= disp_src;
              void_q <= disp_void;
              bcnt_q <= 5'd0;
            end
          end
          S_ADDR: begin
            addr_q <= addr_w;
            bcnt_q <= bcnt_q + 5'd1;
            if (bcnt_q == `SFX_ADDR_BITS - 5'd1) begin
              bcnt_q <= 5'd0;
              st_q <= S_OUT;
              case (op_q)
                `SFX_OP_READ: begin
                  src_q <= SRC_DATA;
                  fetch_q <= 1'b1;
                  mem_req_addr <= addr_w;
                end
                `SFX_OP_FAST: st_q <= S_DUMMY;
                `SFX_OP_RDID: begin
                  src_q <= SRC_ID;
                  idx_q <= 2'd0;
                end
                default: begin
                  src_q <= SRC_ID;
                  idx_q <= 2'd1;
                end
              endcase
            end
          end
          S_DUMMY: begin
            bcnt_q <= bcnt_q + 5'd1;
            // Early fetch hides buffer latency behind the dummy byte
            if (bcnt_q == 5'd0) begin
              fetch_q <= 1'b1;
              mem_req_addr <= addr_q;
            end
            if (bcnt_q == `SFX_DUMMY_BITS - 5'd1) begin
              st_q <= S_OUT;
              src_q <= SRC_DATA;
            end
          end
          S_WDATA: begin
            sh_in_q <= op_w;
            wpos_q <= wpos_q + 3'd1;
            if (wpos_q == 3'd7) begin
              wbyte_q <= op_w;
              wgot_q <= 1'b1;
            end
          end
          S_HOLD: extra_q <= 1'b1;
          default: st_q <= st_q;
        endcase
      end else if (ck_fall && st_q == S_OUT) begin
        serial_out_oe <= 1'b1;
        if (ocnt_q == 3'd0) begin
          serial_out <= nb[7];
          osh_q <= {nb[6:0], 1'b0};
          ocnt_q <= 3'd7;
          if (src_q == SRC_JID) begin
            idx_q <= (idx_q == 2'd2) ? 2'd0 : idx_q + 2'd1;
          end else if (src_q == SRC_ID && op_q == `SFX_OP_MFID) begin
            idx_q <= (idx_q == 2'd1) ? 2'd2 : 2'd1;
          end
        end else begin
          serial_out <= osh_q[7];
          osh_q <= {osh_q[6:0], 1'b0};
          ocnt_q <= ocnt_q - 3'd1;
        end
      end
    end
  end

  // Read buffer; a stalled consumer only holds back requests, never drops data
  always @(posedge ref_clk) begin
    if (srst) begin
      fifo_q[0] <= 8'h00;
      fifo_q[1] <= 8'h00;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      fcnt_q <= 2'd0;
      outst_q <= 2'd0;
      req_pend_q <= 1'b0;
      drain_q <= 1'b0;
    end else if (clk_en) begin
      req_pend_q <= mem_req_valid & ~mem_req_ready;
      // Replies owed to an ended frame must never land in the next one
      if (cs_rise && (outst_q != 2'd0 || mem_req_valid)) begin
        drain_q <= 1'b1;
      end else if (outst_q == 2'd0 && !mem_req_valid) begin
        drain_q <= 1'b0;
      end
      if (push) begin
        fifo_q[wr_ptr_q] <= mem_rd_data;
      end
      if (cs_fall) begin
        wr_ptr_q <= 1'b0;
        rd_ptr_q <= 1'b0;
        fcnt_q <= 2'd0;
      end else begin
        if (push) begin
          wr_ptr_q <= ~wr_ptr_q;
        end
        if (pop) begin
          rd_ptr_q <= ~rd_ptr_q;
        end
        if (push && !pop) begin
          fcnt_q <= fcnt_q + 2'd1;
        end else if (pop && !push) begin
          fcnt_q <= fcnt_q - 2'd1;
        end
      end
      if (req_fire && !rsp_fire) begin
        outst_q <= outst_q + 2'd1;
      end else if (rsp_fire && !req_fire && outst_q != 2'd0) begin
        outst_q <= outst_q - 2'd1;
      end
    end
  end

endmodule

// ---- sim/sfx_flash_front_checker.sv ----
`timescale 1ns/1ps
module sfx_flash_front_checker #(
  parameter ADDR_W = 24,
  parameter TW_CYCLES = 1500000
) (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire chip_sel_n,
  input wire serial_out_oe,
  input wire mem_req_valid,
  input wire mem_req_ready,
  input wire [ADDR_W-1:0] mem_req_addr,
  input wire [7:0] status_out,
  input wire [2:0] block_guard,
  input wire busy
);
  reg [31:0] bcnt_q;
  // Busy run length in enabled cycles, since a frozen block does not advance
  always @(posedge ref_clk) begin
    if (srst || !busy) begin
      bcnt_q <= 32'h0;
    end else if (clk_en) begin
      bcnt_q <= bcnt_q + 32'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  reset_idle_a: assert property (
    disable iff (1'b0) srst |=> !busy && status_out == 8'h00 && !serial_out_oe)
    else $error("outputs not idle after reset");
  guard_mirror_a: assert property (
    block_guard == status_out[4:2] && busy == status_out[0] && !status_out[6])
    else $error("status fields disagree");
  oe_release_a: assert property (
    (chip_sel_n && clk_en) [*6] |-> !serial_out_oe)
    else $error("output driven while deselected");
  req_hold_a: assert property (
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr))
    else $error("fetch request dropped");
  busy_fetch_a: assert property (
    busy && $past(busy, 4) |-> !mem_req_valid)
    else $error("array fetch while busy");
  busy_len_a: assert property (
    $fell(busy) |-> bcnt_q >= TW_CYCLES && bcnt_q <= TW_CYCLES + 1 && !status_out[1])
    else $error("busy length or latch wrong");
  latch_set_a: assert property (
    $rose(status_out[1]) |-> $past(chip_sel_n, 2) && !busy)
    else $error("latch set outside deselect");
  bits_deselect_a: assert property (
    $changed(status_out[7:2]) |-> $past(chip_sel_n, 2) || $past(busy))
    else $error("status bits changed mid frame");
  busy_start_a: assert property (
    $rose(busy) |-> $past(chip_sel_n, 2))
    else $error("busy started mid frame");
endmodule
bind sfx_flash_front sfx_flash_front_checker #(.ADDR_W(ADDR_W), .TW_CYCLES(TW_CYCLES)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
  .serial_out_oe(serial_out_oe), .mem_req_valid(mem_req_valid),
  .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
  .status_out(status_out), .block_guard(block_guard), .busy(busy));

// ---- sim/sfx_mem_model.sv ----
`timescale 1ns/1ps
module sfx_mem_model (
  input wire ref_clk,
  input wire srst,
  input wire slow,
  input wire mem_req_valid,
  output logic mem_req_ready,
  input wire [23:0] mem_req_addr,
  output logic mem_rd_valid,
  input wire mem_rd_ready,
  output logic [7:0] mem_rd_data
);
  logic [7:0] q[$];
  always @(posedge ref_clk) begin
    if (srst) begin
      q.delete();
      mem_req_ready <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 8'h00;
    end else begin
      if (mem_req_valid && mem_req_ready) begin
        q.push_back(mem_req_addr[7:0] ^ mem_req_addr[15:8] ^ 8'h5a);
      end
      mem_req_ready <= slow ? 1'($urandom()) : 1'b1;
      // Held until taken; idle data inverted so a stale sample cannot pass
      if (!mem_rd_valid || mem_rd_ready) begin
        if (q.size() > 0 && (!slow || 1'($urandom()))) begin
          mem_rd_data <= q.pop_front();
          mem_rd_valid <= 1'b1;
        end else begin
          mem_rd_data <= ~mem_rd_data;
          mem_rd_valid <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`include "sfx_consts.vh"
module tb;
  logic ref_clk = 0, srst = 1, chip_sel_n = 1, ser_clk = 0, serial_in = 0;
  logic write_guard_n = 1, slow = 0, clk_en = 1;
  wire serial_out, serial_out_oe, mem_req_valid, mem_req_ready, mem_rd_valid;
  wire mem_rd_ready, busy;
  wire [23:0] mem_req_addr;
  wire [7:0] mem_rd_data, status_out;
  wire [2:0] block_guard;
  int fail_count = 0, comparisons = 0, cyc = 0;
  logic [7:0] b, s, d;
  logic [23:0] a;
  always #5 ref_clk = ~ref_clk;
  sfx_flash_front #(.TW_CYCLES(2000)) DUT (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .chip_sel_n(chip_sel_n), .ser_clk(ser_clk), .serial_in(serial_in),
    .write_guard_n(write_guard_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_addr(mem_req_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
    .mem_rd_data(mem_rd_data), .status_out(status_out), .block_guard(block_guard),
    .busy(busy));
  sfx_mem_model u_mem (.ref_clk(ref_clk), .srst(srst), .slow(slow),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_addr(mem_req_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_ready(mem_rd_ready), .mem_rd_data(mem_rd_data));
  task final_report;
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  function logic [7:0] mem(input logic [23:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5a;
  endfunction
  function logic [7:0] nv(input logic [7:0] old, input logic [7:0] v);
    return (old & 8'h43) | (v & 8'hbc);
  endfunction
  // Half of an 80 ns link clock period
  task half;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      serial_in = tx[7-i];
      half();
      rx = {rx[6:0], serial_out};
      ser_clk = 1;
      half();
      ser_clk = 0;
    end
  endtask
  task fs;
    half();
    chip_sel_n = 0;
  endtask
  task fe;
    half();
    chip_sel_n = 1;
    repeat (8) half();
  endtask
  task op(input logic [7:0] c);
    fs();
    xb(c, 8, b);
    fe();
  endtask
  task rdsr(output logic [7:0] r);
    fs();
    xb(`SFX_OP_RDSR, 8, r);
    xb(8'h00, 8, r);
    fe();
  endtask
  task wrsr(input logic [7:0] v, input int n);
    fs();
    xb(`SFX_OP_WRSR, 8, b);
    xb(v, n, b);
    fe();
  endtask
  initial begin
    void'($urandom(32'h99f25cdc));
    repeat (12) @(posedge ref_clk);
    #1 srst = 0;
    rdsr(s);
    chk(s, 8'h00);
    op(`SFX_OP_WREN);
    fs();
    xb(`SFX_OP_RDSR, 8, b);
    xb(8'h00, 8, s);
    xb(8'h00, 8, b);
    fe();
    chk(s, 8'h02);
    chk(b, 8'h02);
    wrsr(8'hff, 7);
    rdsr(s);
    chk(s, 8'h02);
    op(`SFX_OP_WRDI);
    rdsr(s);
    chk(s, 8'h00);
    wrsr(8'hff, 8);
    rdsr(s);
    chk(s, 8'h00);
    d = 8'($urandom()) & 8'h7f;
    op(`SFX_OP_WREN);
    wrsr(d, 8);
    rdsr(s);
    chk(s, 8'h03);
    fs();
    for (int i = 0; i < 5; i++) xb(i == 0 ? `SFX_OP_READ : 8'($urandom()), 8, b);
    chk({7'h0, serial_out_oe}, 8'h00);
    fe();
    op(`SFX_OP_WREN);
    repeat (30) if (s[0] === 1'b1) rdsr(s);
    chk(s, nv(8'h00, d));
    d = 8'($urandom()) & 8'h3c;
    op(`SFX_OP_VOLEN);
    wrsr(d, 8);
    chk(status_out, d);
    chk({7'h0, busy}, 8'h00);
    op(`SFX_OP_VOLEN);
    wrsr(8'h80, 8);
    write_guard_n = 0;
    op(`SFX_OP_VOLEN);
    wrsr(8'h1c, 8);
    chk(status_out, 8'h80);
    write_guard_n = 1;
    op(`SFX_OP_VOLEN);
    wrsr(8'h00, 8);
    chk(status_out, 8'h00);
    clk_en = 0;
    op(`SFX_OP_WREN);
    clk_en = 1;
    rdsr(s);
    chk(s, 8'h00);
    fs();
    xb(8'h77, 8, b);
    xb(8'h00, 8, b);
    chk({7'h0, serial_out_oe}, 8'h00);
    fe();
    for (int k = 0; k < 2; k++) begin
      a = 24'($urandom()) | 24'hfc;
      slow = k[0];
      fs();
      xb(k ? `SFX_OP_FAST : `SFX_OP_READ, 8, b);
      for (int i = 0; i < 3 + k; i++) xb(8'(a >> (16 - 8 * i)), 8, b);
      for (int i = 0; i < 6; i++) begin
        xb(8'($urandom()), 8, b);
        chk(b, mem(a + 24'(i)));
      end
      fe();
    end
    fs();
    xb(`SFX_OP_STDID, 8, b);
    for (int i = 0; i < 4; i++) begin
      xb(8'h00, 8, b);
      chk(b, i == 1 ? `SFX_MEM_TYPE : i == 2 ? `SFX_CAPACITY : `SFX_MFR_ID);
    end
    fe();
    fs();
    xb(`SFX_OP_RDID, 8, b);
    for (int i = 0; i < 5; i++) xb(8'h00, 8, b);
    chk(b, `SFX_DEV_ID);
    chk({7'h0, serial_out_oe}, 8'h01);
    fe();
    fs();
    xb(`SFX_OP_MFID, 8, b);
    for (int i = 0; i < 4; i++) xb(8'h00, 8, b);
    xb(8'h00, 8, s);
    chk(b, `SFX_MFR_ID);
    chk(s, `SFX_DEV_ID);
    fe();
    final_report();
  end
endmodule
